/* pkg/mpc_pkg.sv */
// Purpose: Shared constants and types for the multifunction pin configuration block.
// Assumes: Registers sit on a 32-bit Avalon-MM slave, one aligned word per register.
// Notes: Register indices are kept as printed; the byte address is four times the index.

package mpc_pkg;

   // Register indices and bus geometry.
   localparam int ADDR_W = 10;
   localparam logic [7:0] IDX_OUT_PIN_CFG = 8'h22;
   localparam logic [7:0] IDX_OUT_LEVELS = 8'h29;
   localparam logic [7:0] IDX_BIDIR_MON = 8'h2A;
   localparam logic [7:0] IDX_IN_PINS_CFG = 8'h2B;
   localparam logic [7:0] IDX_IN_MON = 8'h2F;

   // Field positions.
   localparam int OUT_FUNC_LSB = 4;
   localparam int OUT_DRV_LSB = 0;
   localparam int BIDIR_LEVEL_BIT = 7;
   localparam int OUT_LEVEL_BIT = 6;
   localparam int BIDIR_SENSE_BIT = 7;
   localparam int IN_A_FUNC_LSB = 4;
   localparam int IN_B_FUNC_LSB = 0;
   localparam int IN_A_SENSE_BIT = 7;
   localparam int IN_B_SENSE_BIT = 6;

   // Reset values and writable-bit masks.
   localparam logic [7:0] RST_OUT_PIN_CFG = 8'h00;
   localparam logic [7:0] RST_OUT_LEVELS = 8'h00;
   localparam logic [7:0] RST_MON = 8'h00;
   localparam logic [7:0] RST_IN_PINS_CFG = 8'h00;
   localparam logic [7:0] WMASK_OUT_PIN_CFG = 8'hF7;
   localparam logic [7:0] WMASK_OUT_LEVELS = 8'hC0;
   localparam logic [7:0] WMASK_IN_PINS_CFG = 8'h77;

   typedef enum logic [3:0] {
      OUT_FN_OFF = 4'h0,
      OUT_FN_GPO = 4'h1,
      OUT_FN_IRQ = 4'h2,
      OUT_FN_PDM_CLK = 4'h4
   } mpc_out_func_t;

   typedef enum logic [2:0] {
      DRV_HIZ = 3'h0,
      DRV_PUSH_PULL = 3'h1,
      DRV_LOW_ONLY = 3'h3,
      DRV_HIGH_ONLY = 3'h5
   } mpc_drive_t;

   typedef enum logic [2:0] {
      IN_FN_OFF = 3'h0,
      IN_FN_GPI = 3'h1,
      IN_FN_MCLK = 3'h2,
      IN_FN_SERIAL = 3'h3,
      IN_FN_PDM_A = 3'h4,
      IN_FN_PDM_B = 3'h5,
      IN_FN_ADC_PD = 3'h7
   } mpc_in_func_t;

   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } mpc_avm_req_t;

   typedef struct packed {
      logic master_clock;
      logic serial_audio_in;
      logic pdm_data_in_pair_a;
      logic pdm_data_in_pair_b;
      logic adc_power_down;
   } mpc_in_route_t;

endpackage

/* design/mpc_sync2.sv */
// Purpose: Two flip-flop synchroniser for one pin level.
// Assumes: Single core clock, asynchronous active-low reset.
// Notes: The first stage feeds only the second stage.

`timescale 1ns/100ps

module mpc_sync2 (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Level in and out
   input wire logic level_in,
   output logic level_out
);

   logic meta_r;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= 1'b0;
         level_out <= 1'b0;
      end else begin
         meta_r <= level_in;
         level_out <= meta_r;
      end
   end

endmodule

/* design/mpc_pin_drive.sv */
// Purpose: Turns a drive-mode code and a wanted level into pin output and enable.
// Assumes: Enable high means the pin is driven.
// Notes: Reserved drive codes leave the pin undriven.

`timescale 1ns/100ps

module mpc_pin_drive (
   // Configuration
   input wire logic [2:0] drive_sel,
   input wire logic active,
   // Level to present
   input wire logic level,
   // Pin side
   output logic pin_o,
   output logic pin_oe
);

   always_comb begin
      pin_o = 1'b0;
      pin_oe = 1'b0;
      if (active) begin
         case (mpc_pkg::mpc_drive_t'(drive_sel))
            mpc_pkg::DRV_PUSH_PULL: begin
               pin_o = level;
               pin_oe = 1'b1;
            end
            // Open-drain style: only a low is driven, high floats.
            mpc_pkg::DRV_LOW_ONLY: begin
               pin_o = 1'b0;
               pin_oe = ~level;
            end
            // Open-source style: only a high is driven, low floats.
            mpc_pkg::DRV_HIGH_ONLY: begin
               pin_o = 1'b1;
               pin_oe = level;
            end
            default: begin
               pin_o = 1'b0;
               pin_oe = 1'b0;
            end
         endcase
      end
   end

endmodule

/* design/mpc_pin_config.sv */
// Purpose: Configuration, level and monitor logic for the multifunction pins.
// Assumes: Pin inputs are asynchronous to core_clk and pass through two-flop synchronisers; registers reached over Avalon-MM.
// Notes: The bidirectional pin's own configuration arrives as two input levels.
//
// Chosen here: the Avalon-MM register port.

`timescale 1ns/100ps

module mpc_pin_config (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Avalon-MM register slave
   input wire mpc_pkg::mpc_avm_req_t avm_req,
   output logic [31:0] avm_readdata,
   output logic avm_waitrequest,
   // Bidirectional pin mode, set by its own configuration elsewhere
   input wire logic bidir_pin_is_output,
   input wire logic bidir_pin_is_input,
   // Internal sources for the output-only pin
   input wire logic device_irq,
   input wire logic pdm_bit_clock_out,
   // Shared analog output pin
   output logic shared_analog_out_pin_o,
   output logic shared_analog_out_pin_oe,
   // Bidirectional pin
   input wire logic bidir_pin_i,
   output logic bidir_pin_o,
   output logic bidir_pin_oe,
   // Input-capable pins
   input wire logic shared_analog_in_pin_i,
   input wire logic bias_supply_pin_i,
   // Input functions routed to the core
   output mpc_pkg::mpc_in_route_t in_route,
   output logic bias_supply_pin_as_input
);

   typedef enum logic {
      BUS_IDLE,
      BUS_DONE
   } mpc_bus_state_t;

   // Register decode: a hit needs an aligned word at a mapped index.
   function automatic logic reg_hit(input logic [mpc_pkg::ADDR_W-1:0] addr);
      logic [7:0] idx;
      idx = addr[mpc_pkg::ADDR_W-1:2];
      reg_hit = (addr[1:0] == 2'h0) &&
         ((idx == mpc_pkg::IDX_OUT_PIN_CFG) || (idx == mpc_pkg::IDX_OUT_LEVELS) ||
          (idx == mpc_pkg::IDX_BIDIR_MON) || (idx == mpc_pkg::IDX_IN_PINS_CFG) ||
          (idx == mpc_pkg::IDX_IN_MON));
   endfunction

   function automatic logic is_reg(input logic [mpc_pkg::ADDR_W-1:0] addr, input logic [7:0] idx);
      is_reg = (addr[1:0] == 2'h0) && (addr[mpc_pkg::ADDR_W-1:2] == idx);
   endfunction

   // Input-pin role match, shared by both input pins.
   function automatic logic in_role(input logic [2:0] sel, input mpc_pkg::mpc_in_func_t role);
      in_role = (sel == role);
   endfunction

   // Storage
   logic [7:0] out_pin_cfg_r;
   logic [7:0] out_levels_r;
   logic [7:0] in_pins_cfg_r;
   logic [7:0] bidir_mon_r;
   logic [7:0] in_mon_r;
   mpc_bus_state_t bus_state_r;
   mpc_bus_state_t bus_state_nxt;

   // Field views
   logic [3:0] out_pin_function_sel;
   logic [2:0] out_pin_drive_sel;
   logic out_pin_level;
   logic bidir_pin_level;
   logic [2:0] in_pin_a_function_sel;
   logic [2:0] in_pin_b_function_sel;

   // Synchronised pin levels: bidir, input A, input B.
   logic [2:0] pin_raw;
   logic [2:0] pin_sync;

   // Output pin path
   logic out_active;
   logic out_source;
   logic out_pin_o_nxt;
   logic out_pin_oe_nxt;

   // Bus handshake
   logic bus_req;
   logic bus_commit;
   logic bus_wr_commit;
   logic [7:0] rd_byte;

   assign out_pin_function_sel = out_pin_cfg_r[mpc_pkg::OUT_FUNC_LSB +: 4];
   assign out_pin_drive_sel = out_pin_cfg_r[mpc_pkg::OUT_DRV_LSB +: 3];
   assign out_pin_level = out_levels_r[mpc_pkg::OUT_LEVEL_BIT];
   assign bidir_pin_level = out_levels_r[mpc_pkg::BIDIR_LEVEL_BIT];
   assign in_pin_a_function_sel = in_pins_cfg_r[mpc_pkg::IN_A_FUNC_LSB +: 3];
   assign in_pin_b_function_sel = in_pins_cfg_r[mpc_pkg::IN_B_FUNC_LSB +: 3];

   // ------------------------------------------------------------------
   // Avalon-MM slave.
   // A request is taken in BUS_IDLE, waitrequest drops in the next cycle,
   // and the write or read completes at the edge that sees it low.
   // ------------------------------------------------------------------
   assign bus_req = avm_req.read | avm_req.write;
   assign avm_waitrequest = bus_req & (bus_state_r != BUS_DONE);
   assign bus_commit = bus_req & (bus_state_r == BUS_DONE);
   assign bus_wr_commit = bus_commit & avm_req.write & avm_req.byteenable[0] & reg_hit(avm_req.address);

   always_comb begin
      bus_state_nxt = bus_state_r;
      case (bus_state_r)
         BUS_IDLE: begin
            if (bus_req) begin
               bus_state_nxt = BUS_DONE;
            end
         end
         BUS_DONE: begin
            bus_state_nxt = BUS_IDLE;
         end
         default: begin
            bus_state_nxt = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bus_state_r <= BUS_IDLE;
      end else begin
         bus_state_r <= bus_state_nxt;
      end
   end

   // Read mux; unmapped or misaligned addresses read as zero.
   always_comb begin
      rd_byte = 8'h00;
      if (is_reg(avm_req.address, mpc_pkg::IDX_OUT_PIN_CFG)) begin
         rd_byte = out_pin_cfg_r;
      end else if (is_reg(avm_req.address, mpc_pkg::IDX_OUT_LEVELS)) begin
         rd_byte = out_levels_r;
      end else if (is_reg(avm_req.address, mpc_pkg::IDX_BIDIR_MON)) begin
         rd_byte = bidir_mon_r;
      end else if (is_reg(avm_req.address, mpc_pkg::IDX_IN_PINS_CFG)) begin
         rd_byte = in_pins_cfg_r;
      end else if (is_reg(avm_req.address, mpc_pkg::IDX_IN_MON)) begin
         rd_byte = in_mon_r;
      end
   end

   // Read data is captured when the request is taken so it stands stable
   // through the cycle in which waitrequest is low.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         avm_readdata <= 32'h0000_0000;
      end else if (bus_req && bus_state_r == BUS_IDLE && avm_req.read) begin
         avm_readdata <= {24'h00_0000, rd_byte};
      end
   end

   // ------------------------------------------------------------------
   // Configuration and level registers.
   // Reserved bits are masked off, so they always read as zero even if
   // software breaks the write-zero convention.
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         out_pin_cfg_r <= mpc_pkg::RST_OUT_PIN_CFG;
      end else if (bus_wr_commit && is_reg(avm_req.address, mpc_pkg::IDX_OUT_PIN_CFG)) begin
         out_pin_cfg_r <= avm_req.writedata[7:0] & mpc_pkg::WMASK_OUT_PIN_CFG;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         out_levels_r <= mpc_pkg::RST_OUT_LEVELS;
      end else if (bus_wr_commit && is_reg(avm_req.address, mpc_pkg::IDX_OUT_LEVELS)) begin
         out_levels_r <= avm_req.writedata[7:0] & mpc_pkg::WMASK_OUT_LEVELS;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         in_pins_cfg_r <= mpc_pkg::RST_IN_PINS_CFG;
      end else if (bus_wr_commit && is_reg(avm_req.address, mpc_pkg::IDX_IN_PINS_CFG)) begin
         in_pins_cfg_r <= avm_req.writedata[7:0] & mpc_pkg::WMASK_IN_PINS_CFG;
      end
   end

   // ------------------------------------------------------------------
   // Pin level synchronisers.
   // ------------------------------------------------------------------
   assign pin_raw = {bias_supply_pin_i, shared_analog_in_pin_i, bidir_pin_i};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         mpc_sync2 u_sync (
            .core_clk(core_clk),
            .resetn(resetn),
            .level_in(pin_raw[gi]),
            .level_out(pin_sync[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // Monitor registers. A bit follows its pin only while that pin is a
   // general input; otherwise it reads zero so stale levels never show.
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bidir_mon_r <= mpc_pkg::RST_MON;
      end else begin
         bidir_mon_r <= 8'h00;
         bidir_mon_r[mpc_pkg::BIDIR_SENSE_BIT] <= bidir_pin_is_input & pin_sync[0];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         in_mon_r <= mpc_pkg::RST_MON;
      end else begin
         in_mon_r <= 8'h00;
         in_mon_r[mpc_pkg::IN_A_SENSE_BIT] <= in_role(in_pin_a_function_sel, mpc_pkg::IN_FN_GPI) & pin_sync[1];
         in_mon_r[mpc_pkg::IN_B_SENSE_BIT] <= in_role(in_pin_b_function_sel, mpc_pkg::IN_FN_GPI) & pin_sync[2];
      end
   end

   // ------------------------------------------------------------------
   // Input function routing. Either input pin may take any role; if both
   // take the same role their levels are ORed. Routing through the
   // synchroniser limits a master clock to well under half the core rate.
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         in_route <= '0;
      end else begin
         in_route.master_clock <= (in_role(in_pin_a_function_sel, mpc_pkg::IN_FN_MCLK) & pin_sync[1]) |
            (in_role(in_pin_b_function_sel, mpc_pkg::IN_FN_MCLK) & pin_sync[2]);
         in_route.serial_audio_in <= (in_role(in_pin_a_function_sel, mpc_pkg::IN_FN_SERIAL) & pin_sync[1]) |
            (in_role(in_pin_b_function_sel, mpc_pkg::IN_FN_SERIAL) & pin_sync[2]);
         in_route.pdm_data_in_pair_a <= (in_role(in_pin_a_function_sel, mpc_pkg::IN_FN_PDM_A) & pin_sync[1]) |
            (in_role(in_pin_b_function_sel, mpc_pkg::IN_FN_PDM_A) & pin_sync[2]);
         in_route.pdm_data_in_pair_b <= (in_role(in_pin_a_function_sel, mpc_pkg::IN_FN_PDM_B) & pin_sync[1]) |
            (in_role(in_pin_b_function_sel, mpc_pkg::IN_FN_PDM_B) & pin_sync[2]);
         // A high level on a pin set to the power-down role halts all ADC channels.
         in_route.adc_power_down <= (in_role(in_pin_a_function_sel, mpc_pkg::IN_FN_ADC_PD) & pin_sync[1]) |
            (in_role(in_pin_b_function_sel, mpc_pkg::IN_FN_ADC_PD) & pin_sync[2]);
      end
   end

   // The bias supply must stand off while its pin serves as an input.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bias_supply_pin_as_input <= 1'b0;
      end else begin
         bias_supply_pin_as_input <= (in_pin_b_function_sel != mpc_pkg::IN_FN_OFF);
      end
   end

   // ------------------------------------------------------------------
   // Output-only pin. Reserved function codes behave as disabled.
   // ------------------------------------------------------------------
   always_comb begin
      out_active = 1'b0;
      out_source = 1'b0;
      case (mpc_pkg::mpc_out_func_t'(out_pin_function_sel))
         mpc_pkg::OUT_FN_GPO: begin
            out_active = 1'b1;
            out_source = out_pin_level;
         end
         mpc_pkg::OUT_FN_IRQ: begin
            out_active = 1'b1;
            out_source = device_irq;
         end
         mpc_pkg::OUT_FN_PDM_CLK: begin
            out_active = 1'b1;
            out_source = pdm_bit_clock_out;
         end
         default: begin
            out_active = 1'b0;
            out_source = 1'b0;
         end
      endcase
   end

   mpc_pin_drive u_out_drive (
      .drive_sel(out_pin_drive_sel),
      .active(out_active),
      .level(out_source),
      .pin_o(out_pin_o_nxt),
      .pin_oe(out_pin_oe_nxt)
   );

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         shared_analog_out_pin_o <= 1'b0;
         shared_analog_out_pin_oe <= 1'b0;
      end else begin
         shared_analog_out_pin_o <= out_pin_o_nxt;
         shared_analog_out_pin_oe <= out_pin_oe_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Bidirectional pin output side.
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bidir_pin_o <= 1'b0;
         bidir_pin_oe <= 1'b0;
      end else begin
         bidir_pin_o <= bidir_pin_is_output & bidir_pin_level;
         bidir_pin_oe <= bidir_pin_is_output;
      end
   end

endmodule

/* verification/mpc_pin_config_assertions.sv */
// Purpose: Concurrent checks on the ports of the multifunction pin configuration block.
// Assumes: Register writes are seen on the bus and mirrored here in shadow registers.
// Notes: Only byte lane 0 of completed writes to mapped words updates the shadows.
`timescale 1ns/100ps
module mpc_pin_config_assertions (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Register bus
   input wire mpc_pkg::mpc_avm_req_t avm_req,
   input wire logic [31:0] avm_readdata,
   input wire logic avm_waitrequest,
   // Sources and pins
   input wire logic bidir_pin_is_output,
   input wire logic device_irq,
   input wire logic pdm_bit_clock_out,
   input wire logic shared_analog_out_pin_o,
   input wire logic shared_analog_out_pin_oe,
   input wire logic bidir_pin_o,
   input wire logic bidir_pin_oe,
   input wire logic shared_analog_in_pin_i,
   input wire logic bias_supply_pin_i,
   input wire mpc_pkg::mpc_in_route_t in_route,
   input wire logic bias_supply_pin_as_input
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic wr_done;
   logic [7:0] out_cfg_r, lvl_r, in_cfg_r;
   logic [2:0] pa_r, pb_r, stab_r;
   logic [1:0] out_exp;
   logic [4:0] route_exp;
   function automatic logic [1:0] drive(input logic [7:0] c, input logic [7:0] l, input logic irq, input logic pdm);
      logic act;
      logic s;
      act = c[7:4] == 4'h1 || c[7:4] == 4'h2 || c[7:4] == 4'h4;
      s = c[7:4] == 4'h1 ? l[6] : (c[7:4] == 4'h2 ? irq : pdm);
      case (c[2:0])
         3'h1: return {act, s};
         3'h3: return {act && !s, 1'b0};
         3'h5: return {act && s, 1'b1};
         default: return 2'b00;
      endcase
   endfunction
   function automatic logic sel(input logic [7:0] c, input logic a, input logic b, input logic [2:0] r);
      return (c[6:4] == r && a) || (c[2:0] == r && b);
   endfunction
   assign wr_done = avm_req.write && !avm_waitrequest && avm_req.byteenable[0];
   assign out_exp = drive(out_cfg_r, lvl_r, device_irq, pdm_bit_clock_out);
   assign route_exp = {sel(in_cfg_r, pa_r[2], pb_r[2], 3'h2), sel(in_cfg_r, pa_r[2], pb_r[2], 3'h3),
      sel(in_cfg_r, pa_r[2], pb_r[2], 3'h4), sel(in_cfg_r, pa_r[2], pb_r[2], 3'h5),
      sel(in_cfg_r, pa_r[2], pb_r[2], 3'h7)};
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         out_cfg_r <= mpc_pkg::RST_OUT_PIN_CFG;
         lvl_r <= mpc_pkg::RST_OUT_LEVELS;
         in_cfg_r <= mpc_pkg::RST_IN_PINS_CFG;
      end else if (wr_done) begin
         if (avm_req.address == {mpc_pkg::IDX_OUT_PIN_CFG, 2'b00}) begin
            out_cfg_r <= avm_req.writedata[7:0] & mpc_pkg::WMASK_OUT_PIN_CFG;
         end
         if (avm_req.address == {mpc_pkg::IDX_OUT_LEVELS, 2'b00}) begin
            lvl_r <= avm_req.writedata[7:0] & mpc_pkg::WMASK_OUT_LEVELS;
         end
         if (avm_req.address == {mpc_pkg::IDX_IN_PINS_CFG, 2'b00}) begin
            in_cfg_r <= avm_req.writedata[7:0] & mpc_pkg::WMASK_IN_PINS_CFG;
         end
      end
   end
   // The route register needs two edges after a select change before old picks are gone.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stab_r <= 3'h0;
      end else if (wr_done && avm_req.address == {mpc_pkg::IDX_IN_PINS_CFG, 2'b00}) begin
         stab_r <= 3'h0;
      end else if (stab_r != 3'h4) begin
         stab_r <= stab_r + 3'h1;
      end
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pa_r <= 3'h0;
         pb_r <= 3'h0;
      end else begin
         pa_r <= {pa_r[1:0], shared_analog_in_pin_i};
         pb_r <= {pb_r[1:0], bias_supply_pin_i};
      end
   end
   sequence s_taken;
      (avm_req.read || avm_req.write) && avm_waitrequest;
   endsequence
   sequence s_answer;
      !avm_waitrequest;
   endsequence
   a_bus_one_wait: assert property (s_taken |=> s_answer)
      else $error("bus answer not one cycle after request");
   a_read_upper_zero: assert property (avm_req.read && !avm_waitrequest |-> avm_readdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_out_pin_drive: assert property (shared_analog_out_pin_oe == $past(out_exp[1]) &&
      (!shared_analog_out_pin_oe || shared_analog_out_pin_o == $past(out_exp[0])))
      else $error("output pin drive does not match configuration");
   a_bidir_enable: assert property ($past(resetn) |-> bidir_pin_oe == $past(bidir_pin_is_output))
      else $error("bidirectional pin enable wrong");
   a_bidir_level: assert property (bidir_pin_oe && $stable(lvl_r[7]) |-> bidir_pin_o == lvl_r[7])
      else $error("bidirectional pin level wrong");
   a_input_route: assert property (stab_r >= 3'h2 |-> in_route == route_exp)
      else $error("input routing wrong");
   a_bias_as_input: assert property (stab_r >= 3'h2 |-> bias_supply_pin_as_input == (in_cfg_r[2:0] != 3'h0))
      else $error("bias pin input flag wrong");
   a_reset_quiet: assert property ($rose(resetn) |-> !shared_analog_out_pin_oe && !bidir_pin_oe)
      else $error("pins driven right after reset");
endmodule
bind mpc_pin_config mpc_pin_config_assertions chk (.core_clk, .resetn, .avm_req, .avm_readdata,
   .avm_waitrequest, .bidir_pin_is_output, .device_irq, .pdm_bit_clock_out, .shared_analog_out_pin_o,
   .shared_analog_out_pin_oe, .bidir_pin_o, .bidir_pin_oe, .shared_analog_in_pin_i, .bias_supply_pin_i,
   .in_route, .bias_supply_pin_as_input);

/* verification/mpc_board_model.sv */
// Purpose: Board around the pins: pull-up, bidirectional wire and input pin sources.
// Assumes: The bench sets the levels the board presents.
// Notes: The output pin has a pull-up, so an undriven pin reads high, never the last level.
`timescale 1ns/100ps
module mpc_board_model (
   // Levels the board presents
   input wire logic ext_bidir,
   input wire logic ext_a,
   input wire logic ext_b,
   // Device pin drivers
   input wire logic out_o,
   input wire logic out_oe,
   input wire logic bd_o,
   input wire logic bd_oe,
   // Resolved wires
   output logic out_w,
   output logic bd_w,
   output logic pin_a,
   output logic pin_b
);
   assign out_w = out_oe ? out_o : 1'b1;
   // The board lets go of the bidirectional wire while the device drives it.
   assign bd_w = bd_oe ? bd_o : ext_bidir;
   assign pin_a = ext_a;
   assign pin_b = ext_b;
endmodule

/* verification/mpc_pin_config_bench.sv */
// Purpose: Self-checking bench for the multifunction pin configuration block.
// Assumes: The bus master waits for the slave's answer; pins settle within four edges.
// Notes: The bench stands in for host software and keeps to the legal codes.
`timescale 1ns/100ps
module mpc_pin_config_bench;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   mpc_pkg::mpc_avm_req_t avm_req = '0;
   logic is_out = 1'b0, is_in = 1'b0, irq = 1'b0, pdm = 1'b0, ext_bd = 1'b0, lvl_a = 1'b0, lvl_b = 1'b0;
   logic [31:0] avm_readdata, rd;
   logic avm_waitrequest, out_o, out_oe, out_w, bd_o, bd_oe, bd_w, pin_a, pin_b, as_in;
   mpc_pkg::mpc_in_route_t in_route;
   int n_mismatch = 0;
   int tests_run = 0;
   always #50 core_clk = ~core_clk;
   mpc_pin_config dut (.core_clk(core_clk), .resetn(resetn), .avm_req(avm_req), .avm_readdata(avm_readdata),
      .avm_waitrequest(avm_waitrequest), .bidir_pin_is_output(is_out), .bidir_pin_is_input(is_in),
      .device_irq(irq), .pdm_bit_clock_out(pdm), .shared_analog_out_pin_o(out_o),
      .shared_analog_out_pin_oe(out_oe), .bidir_pin_i(bd_w), .bidir_pin_o(bd_o), .bidir_pin_oe(bd_oe),
      .shared_analog_in_pin_i(pin_a), .bias_supply_pin_i(pin_b), .in_route(in_route),
      .bias_supply_pin_as_input(as_in));
   mpc_board_model board (.ext_bidir(ext_bd), .ext_a(lvl_a), .ext_b(lvl_b), .out_o(out_o), .out_oe(out_oe),
      .bd_o(bd_o), .bd_oe(bd_oe), .out_w(out_w), .bd_w(bd_w), .pin_a(pin_a), .pin_b(pin_b));
   task automatic stop_test();
      $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   // Entered just after a rising edge; leaves one idle edge so strobes never toggle twice in a step.
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] be);
      int i;
      avm_req.address <= {idx, 2'b00};
      avm_req.read <= !wr;
      avm_req.write <= wr;
      avm_req.writedata <= {24'h000000, wd};
      avm_req.byteenable <= be;
      for (i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (avm_waitrequest === 1'b0) break;
      end
      rd = avm_readdata;
      avm_req.read <= 1'b0;
      avm_req.write <= 1'b0;
      if (i < 20) begin
         @(posedge core_clk);
      end else begin
         n_mismatch++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d, 4'hF);
   endtask
   task automatic rdchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00, 4'hF);
      check(name, rd, {24'h000000, exp});
   endtask
   task automatic t_reset();
      rdchk("out_cfg", 8'h22, 8'h00);
      rdchk("levels", 8'h29, 8'h00);
      rdchk("bidir_mon", 8'h2A, 8'h00);
      rdchk("in_cfg", 8'h2B, 8'h00);
      rdchk("in_mon", 8'h2F, 8'h00);
      check("out_oe", 32'(out_oe), 32'h0);
      bus(1'b1, 8'h29, 8'hC0, 4'hE);
      rdchk("lane_off", 8'h29, 8'h00);
      wr(8'h30, 8'hFF);
      rdchk("unmapped", 8'h30, 8'h00);
   endtask
   task automatic t_out_pin();
      logic [3:0] fns [4] = '{4'h0, 4'h1, 4'h2, 4'h4};
      logic [2:0] dvs [4] = '{3'h0, 3'h1, 3'h3, 3'h5};
      logic s, ee, eo;
      for (int f = 0; f < 4; f++) begin
         for (int d = 0; d < 4; d++) begin
            wr(8'h22, {fns[f], 1'b0, dvs[d]});
            rdchk("out_cfg", 8'h22, {fns[f], 1'b0, dvs[d]});
            for (int k = 0; k < 4; k++) begin
               wr(8'h29, {1'b0, k[0], 6'h00});
               irq <= k[1];
               pdm <= k[0] ^ k[1];
               @(posedge core_clk);
               @(negedge core_clk);
               s = f == 1 ? k[0] : (f == 2 ? k[1] : k[0] ^ k[1]);
               ee = f != 0 && (d == 1 || (d == 2 && !s) || (d == 3 && s));
               eo = d == 1 ? s : d == 3;
               check("out_oe", 32'(out_oe), 32'(ee));
               check("out_wire", 32'(out_w), 32'(ee ? eo : 1'b1));
               @(posedge core_clk);
            end
         end
      end
   endtask
   task automatic t_bidir();
      is_out <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         wr(8'h29, {k[0], 7'h00});
         @(posedge core_clk);
         @(negedge core_clk);
         check("bidir_oe", 32'(bd_oe), 32'h1);
         check("bidir_wire", 32'(bd_w), 32'(k[0]));
         @(posedge core_clk);
      end
      is_out <= 1'b0;
      is_in <= 1'b1;
      for (int k = 1; k >= 0; k--) begin
         ext_bd <= k[0];
         repeat (4) @(posedge core_clk);
         rdchk("bidir_mon", 8'h2A, {k[0], 7'h00});
      end
   endtask
   function automatic logic role(input logic [2:0] ca, input logic [2:0] cb, input logic [2:0] c, input int v);
      return (ca == c && v[0]) || (cb == c && v[1]);
   endfunction
   task automatic t_inputs();
      logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
      logic [2:0] ca, cb;
      for (int a = 0; a < 7; a++) begin
         ca = codes[a];
         cb = codes[6 - a];
         wr(8'h2B, {1'b0, ca, 1'b0, cb});
         for (int v = 0; v < 4; v++) begin
            lvl_a <= v[0];
            lvl_b <= v[1];
            repeat (4) @(posedge core_clk);
            check("route", 32'(in_route), 32'({role(ca, cb, 3'h2, v), role(ca, cb, 3'h3, v), role(ca, cb, 3'h4, v),
               role(ca, cb, 3'h5, v), role(ca, cb, 3'h7, v)}));
            check("bias_in", 32'(as_in), 32'(cb != 3'h0));
            rdchk("in_mon", 8'h2F, {ca == 3'h1 && v[0], cb == 3'h1 && v[1], 6'h00});
         end
      end
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_out_pin();
      t_bidir();
      t_inputs();
      stop_test();
   end
endmodule
